// ### core/cascade_power_on_sequencer.sv
// cascade power-on sequencer with axi4-lite register slave
// assumes comparator and pin inputs are asynchronous to clock
//
// Our own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`include "cascade_seq_defs.svh"

// Notes on behaviour
// - outputs held off and start refused while battery is below lockout
// - start on enable pin, serial power-on command, or auto-start at lockout clear
// - pin toggle or power-on command starts only from idle; once done, a faulted channel turns on again when its fault clears
// - each channel picks one of four enable signals independently
// - enable stalls power-on, or turns channel off once all supplies are up
// - each enable comes from the pin or a volatile register bit
// - volatile enable register loads its default when lockout clears
// - each channel takes one of four positions, positions may be shared
// - position counter advances only when outputs exceed their thresholds or are bypassed
// - mode is normal, with-enable, with-bypass or manual, held in storage
// - counter starts at position 0, each channel waits its own delay
// - enabled channels of the current position start soft-start
// - fault monitoring starts after channel rises above its threshold
// - next position delay starts when every non-bypassed channel of the position is above threshold
// - with-enable mode stalls a channel until its enable is asserted
// - bypass mode skips a channel whose enable is low when delay expires
// - a lone bypassed channel advances the counter at once
// - a bypassed channel still turns on when its enable rises later
// - manual channels power on by enable alone
// - manual channels ignore sequencing and faults
module cascade_power_on_sequencer
	import cascade_seq_pkg::*;
#(
	parameter int NCH      = 4,
	parameter int DLY0_CYC = `DLY0_US * `CLK_MHZ,
	parameter int DLY1_CYC = `DLY1_US * `CLK_MHZ,
	parameter int DLY2_CYC = `DLY2_US * `CLK_MHZ,
	parameter int DLY3_CYC = `DLY3_US * `CLK_MHZ
) (
	input  wire logic             clock,
	input  wire logic             nrst,
	input  wire logic             clockEn,
	input  wire logic             lockoutClear,
	input  wire logic             powerEnablePin,
	input  wire logic [NCH-1:0]   uvAbove,
	input  wire logic [NCH-1:0]   faultIn,
	output logic      [NCH-1:0]   chanOn,
	output logic      [NCH-1:0]   monitorOn,
	output logic                  seqDone,
	input  wire logic [7:0]       awaddr,
	input  wire logic             awvalid,
	output logic                  awready,
	input  wire logic [31:0]      wdata,
	input  wire logic [3:0]       wstrb,
	input  wire logic             wvalid,
	output logic                  wready,
	output logic      [1:0]       bresp,
	output logic                  bvalid,
	input  wire logic             bready,
	input  wire logic [7:0]       araddr,
	input  wire logic             arvalid,
	output logic                  arready,
	output logic      [31:0]      rdata,
	output logic      [1:0]       rresp,
	output logic                  rvalid,
	input  wire logic             rready
);
	// refuse widths and delays the logic cannot serve
	if (NCH != 4) begin : genBadNch
		$error("only four channels are supported");
	end
	if (DLY0_CYC < 1 || DLY1_CYC < 1 || DLY2_CYC < 1 || DLY3_CYC < 1) begin : genShortDly
		$error("delays must be at least one cycle");
	end
	if (DLY0_CYC > `TIMER_MAX || DLY1_CYC > `TIMER_MAX || DLY2_CYC > `TIMER_MAX
		|| DLY3_CYC > `TIMER_MAX) begin : genLongDly
		$error("delays must fit the position timer");
	end

	typedef struct packed {
		logic [1:0]       lockSync;
		logic [1:0]       pinSync;
		logic [NCH-1:0]   uvS1;
		logic [NCH-1:0]   uvS2;
		logic [NCH-1:0]   fS1;
		logic [NCH-1:0]   fS2;
		logic             pinPrev;
		seqState_t        state;
		logic [1:0]       pos;
		logic [22:0]      timer;
		logic             timing;
		logic [NCH-1:0]   started;
		logic [NCH-1:0]   bypassed;
		logic [NCH-1:0]   on;
		logic [NCH-1:0]   mon;
		logic             done;
		logic             pwrCmd;
		logic             autoStart;
		seqMode_t         mode;
		logic [7:0]       chanPos;
		logic [7:0]       chanEnSel;
		logic [7:0]       chanDly;
		logic [3:0]       enReg;
		logic [3:0]       enDef;
		logic [3:0]       enSrcPin;
		logic             awGot;
		logic [7:0]       awAddrQ;
		logic             wGot;
		logic [31:0]      wDataQ;
		logic             bValid;
		logic [1:0]       bResp;
		logic             rValid;
		logic [31:0]      rData;
		logic [1:0]       rResp;
	} state_t;

	state_t cur_q;
	state_t nxt_d;

	function automatic logic [22:0] dlyCycles(input logic [1:0] sel);
		unique case (sel)
			2'h0: dlyCycles = 23'(DLY0_CYC);
			2'h1: dlyCycles = 23'(DLY1_CYC);
			2'h2: dlyCycles = 23'(DLY2_CYC);
			2'h3: dlyCycles = 23'(DLY3_CYC);
		endcase
	endfunction

	logic [NCH-1:0] enSig;
	logic [NCH-1:0] inPos;
	logic [NCH-1:0] enAvail;
	logic           pinRise;
	logic           startReq;
	logic           posDone;

	// enable selection per channel
	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : genEn
			logic [1:0] sel;
			assign sel = cur_q.chanEnSel[2*g+:2];
			// pin or volatile bit as source
			assign enAvail[g] = cur_q.enSrcPin[g] ? cur_q.pinSync[1] : cur_q.enReg[g];
			assign enSig[g] = enAvail[sel];
			assign inPos[g] = (cur_q.chanPos[2*g+:2] == cur_q.pos);
		end
	endgenerate

	assign pinRise = cur_q.pinSync[1] & ~cur_q.pinPrev;
	assign startReq = pinRise | cur_q.pwrCmd;
	assign posDone = &((~inPos) | cur_q.uvS2 | cur_q.bypassed);

	always_comb begin
		logic wrFire;
		logic [31:0] rd;
		logic [22:0] chDly;
		nxt_d = cur_q;
		wrFire = 1'b0;
		rd = 32'h0;
		chDly = 23'h0;
		nxt_d.lockSync = {cur_q.lockSync[0], lockoutClear};
		nxt_d.pinSync = {cur_q.pinSync[0], powerEnablePin};
		nxt_d.uvS1 = uvAbove;
		nxt_d.uvS2 = cur_q.uvS1;
		nxt_d.fS1 = faultIn;
		nxt_d.fS2 = cur_q.fS1;
		nxt_d.pinPrev = cur_q.pinSync[1];
		nxt_d.pwrCmd = 1'b0;

		unique case (cur_q.state)
			ST_LOCKED: begin
				nxt_d.on = '0;
				nxt_d.mon = '0;
				nxt_d.done = 1'b0;
				if (cur_q.lockSync[1]) begin
					nxt_d.enReg = cur_q.enDef;
					nxt_d.state = cur_q.autoStart ? ST_SEQ : ST_IDLE;
					nxt_d.pos = 2'h0;
					nxt_d.started = '0;
					nxt_d.bypassed = '0;
					nxt_d.timer = '0;
				end
			end
			ST_IDLE: begin
				if (startReq) begin
					nxt_d.state = ST_SEQ;
					nxt_d.pos = 2'h0;
					nxt_d.started = '0;
					nxt_d.bypassed = '0;
					nxt_d.timer = '0;
				end
			end
			ST_SEQ: begin
				nxt_d.timer = cur_q.timer + 23'h1;
				for (int i = 0; i < NCH; i++) begin
					chDly = dlyCycles(cur_q.chanDly[2*i+:2]);
					if (cur_q.mode != MODE_MANUAL && inPos[i] && !cur_q.started[i]
						&& !cur_q.bypassed[i] && cur_q.timer + 23'h1 >= chDly) begin
						if (cur_q.mode == MODE_NORMAL || enSig[i]) begin
							nxt_d.started[i] = 1'b1;
							nxt_d.on[i] = 1'b1;
						end else if (cur_q.mode == MODE_BYPASS) begin
							nxt_d.bypassed[i] = 1'b1;
						end
					end
				end
				if (cur_q.mode != MODE_MANUAL && posDone
					&& &(~inPos | cur_q.started | cur_q.bypassed)) begin
					nxt_d.timer = '0;
					if (cur_q.pos == 2'h3) nxt_d.state = ST_DONE;
					else nxt_d.pos = cur_q.pos + 2'h1;
				end
			end
			ST_DONE: begin
				nxt_d.done = 1'b1;
				for (int i = 0; i < NCH; i++) begin
					if (cur_q.mode != MODE_MANUAL && !cur_q.bypassed[i]) nxt_d.on[i] = enSig[i]
						| (cur_q.mode == MODE_NORMAL);
				end
			end
		endcase

		for (int i = 0; i < NCH; i++) begin
			if (cur_q.bypassed[i] && enSig[i] && cur_q.state != ST_LOCKED)
				nxt_d.on[i] = 1'b1;
			if (cur_q.mode == MODE_MANUAL && cur_q.state != ST_LOCKED)
				nxt_d.on[i] = enSig[i];
			if (cur_q.on[i] && cur_q.uvS2[i] && cur_q.mode != MODE_MANUAL)
				nxt_d.mon[i] = 1'b1;
			if (cur_q.mon[i] && cur_q.fS2[i] && cur_q.mode != MODE_MANUAL)
				nxt_d.on[i] = 1'b0;
		end
		if (!cur_q.lockSync[1]) begin
			nxt_d.state = ST_LOCKED;
			nxt_d.on = '0;
		end

		// axi4-lite write channel
		if (awvalid && !cur_q.awGot) begin
			nxt_d.awGot = 1'b1;
			nxt_d.awAddrQ = awaddr;
		end
		if (wvalid && !cur_q.wGot) begin
			nxt_d.wGot = 1'b1;
			nxt_d.wDataQ = wdata;
		end
		if (cur_q.awGot && cur_q.wGot && !cur_q.bValid) begin
			wrFire = 1'b1;
			nxt_d.awGot = 1'b0;
			nxt_d.wGot = 1'b0;
			nxt_d.bValid = 1'b1;
			nxt_d.bResp = `RESP_OKAY;
		end
		if (cur_q.bValid && bready) nxt_d.bValid = 1'b0;
		if (wrFire) begin
			unique case (cur_q.awAddrQ)
				`ADDR_CTRL: begin
					nxt_d.pwrCmd = cur_q.wDataQ[`CTRL_PWRON_BIT] && cur_q.lockSync[1];
					nxt_d.autoStart = cur_q.wDataQ[`CTRL_AUTO_BIT];
				end
				`ADDR_MODE: nxt_d.mode = seqMode_t'(cur_q.wDataQ[1:0]);
				`ADDR_CHCFG: begin
					nxt_d.chanPos = cur_q.wDataQ[7:0];
					nxt_d.chanEnSel = cur_q.wDataQ[15:8];
					nxt_d.chanDly = cur_q.wDataQ[23:16];
				end
				`ADDR_ENREG: nxt_d.enReg = cur_q.wDataQ[3:0];
				`ADDR_ENDEF: begin
					nxt_d.enDef = cur_q.wDataQ[3:0];
					nxt_d.enSrcPin = cur_q.wDataQ[7:4];
				end
				default: nxt_d.bResp = `RESP_SLVERR;
			endcase
		end

		// axi4-lite read channel
		unique case (araddr)
			`ADDR_CTRL:   rd = {30'h0, cur_q.autoStart, 1'b0};
			`ADDR_MODE:   rd = {30'h0, cur_q.mode};
			`ADDR_CHCFG:  rd = {8'h0, cur_q.chanDly, cur_q.chanEnSel, cur_q.chanPos};
			`ADDR_ENREG:  rd = {28'h0, cur_q.enReg};
			`ADDR_ENDEF:  rd = {24'h0, cur_q.enSrcPin, cur_q.enDef};
			`ADDR_STATUS: rd = {26'h0, cur_q.done, cur_q.pos, cur_q.state, cur_q.lockSync[1]};
			`ADDR_CHSTAT: rd = {20'h0, cur_q.bypassed, cur_q.mon, cur_q.on};
			default:      rd = 32'h0;
		endcase
		if (arvalid && !cur_q.rValid) begin
			nxt_d.rValid = 1'b1;
			nxt_d.rData = rd;
			nxt_d.rResp = (araddr[1:0] == 2'h0 && araddr <= `ADDR_CHSTAT)
				? `RESP_OKAY : `RESP_SLVERR;
		end else if (cur_q.rValid && rready) begin
			nxt_d.rValid = 1'b0;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cur_q <= '0;
			cur_q.enDef <= `ENDEF_RESET;
		end else if (clockEn) begin
			cur_q <= nxt_d;
		end
	end

	assign chanOn    = cur_q.on;
	assign monitorOn = cur_q.mon;
	assign seqDone   = cur_q.done;
	assign awready   = ~cur_q.awGot;
	assign wready    = ~cur_q.wGot;
	assign bvalid    = cur_q.bValid;
	assign bresp     = cur_q.bResp;
	assign arready   = ~cur_q.rValid;
	assign rvalid    = cur_q.rValid;
	assign rdata     = cur_q.rData;
	assign rresp     = cur_q.rResp;

	property pLockOff;
		@(posedge clock) disable iff (!nrst)
		!cur_q.lockSync[1] && clockEn |=> cur_q.on == '0;
	endproperty
	AST_LOCK_OFF: assert property (pLockOff) else $error("channel on under lockout");

	sequence sIdleStart;
		cur_q.state == ST_IDLE && startReq && cur_q.lockSync[1] && clockEn;
	endsequence
	AST_START: assert property (@(posedge clock) disable iff (!nrst)
		sIdleStart |=> cur_q.state == ST_SEQ && cur_q.pos == 2'h0)
		else $error("start trigger ignored");

	AST_POS_HOLD: assert property (@(posedge clock) disable iff (!nrst)
		cur_q.state == ST_SEQ && !posDone |=> $stable(cur_q.pos))
		else $error("position advanced early");

	AST_MON_AFTER_UV: assert property (@(posedge clock) disable iff (!nrst)
		$rose(cur_q.mon[0]) |-> $past(cur_q.uvS2[0]))
		else $error("monitor started before threshold");

	AST_NO_SEQ_START_ENMODE: assert property (@(posedge clock) disable iff (!nrst)
		cur_q.state == ST_SEQ && cur_q.mode == MODE_ENABLE && !enSig[0]
		&& !cur_q.on[0] && clockEn |=> !cur_q.on[0])
		else $error("started without enable");

	AST_MANUAL: assert property (@(posedge clock) disable iff (!nrst)
		cur_q.mode == MODE_MANUAL && cur_q.state != ST_LOCKED && cur_q.lockSync[1]
		&& clockEn && $stable(cur_q.mode) |=> cur_q.on == $past(enSig))
		else $error("manual channel not following enable");

	AST_ENREG_LOAD: assert property (@(posedge clock) disable iff (!nrst)
		cur_q.state == ST_LOCKED && cur_q.lockSync[1] && clockEn
		|=> cur_q.enReg == $past(cur_q.enDef))
		else $error("enable default not loaded");

	AST_DONE: assert property (@(posedge clock) disable iff (!nrst)
		$rose(cur_q.done) |-> $past(cur_q.state) == ST_DONE)
		else $error("done without finishing");

	AST_BVALID_HOLD: assert property (@(posedge clock) disable iff (!nrst)
		bvalid && !bready |=> bvalid)
		else $error("write response dropped");

	AST_FAULT_OFF: assert property (@(posedge clock) disable iff (!nrst)
		cur_q.mon[0] && cur_q.fS2[0] && cur_q.mode != MODE_MANUAL && clockEn
		|=> !cur_q.on[0])
		else $error("monitored channel kept on under fault");
endmodule

// ### core/cascade_seq_defs.svh
// constants for the cascade power-on sequencer
// assumes a 125 MHz core clock
`ifndef CASCADE_SEQ_DEFS_SVH
`define CASCADE_SEQ_DEFS_SVH
`define CLK_MHZ          125
`define DLY0_US          1500
`define DLY1_US          12500
`define DLY2_US          25000
`define DLY3_US          50000
`define CFG_WRITE_MS     10
`define TIMER_MAX        23'h7fffff
`define ADDR_CTRL        8'h00
`define ADDR_MODE        8'h04
`define ADDR_CHCFG       8'h08
`define ADDR_ENREG       8'h0c
`define ADDR_ENDEF       8'h10
`define ADDR_STATUS      8'h14
`define ADDR_CHSTAT      8'h18
`define CTRL_PWRON_BIT   0
`define CTRL_AUTO_BIT    1
`define ENDEF_RESET      4'hf
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2
`endif

// ### core/cascade_seq_pkg.sv
// types for the cascade power-on sequencer
// assumes cascade_seq_defs.svh is compiled alongside
package cascade_seq_pkg;
	typedef enum logic [1:0] {
		MODE_NORMAL = 2'h0,
		MODE_ENABLE = 2'h1,
		MODE_BYPASS = 2'h2,
		MODE_MANUAL = 2'h3
	} seqMode_t;
	typedef enum logic [1:0] {
		ST_LOCKED = 2'h0,
		ST_IDLE   = 2'h1,
		ST_SEQ    = 2'h2,
		ST_DONE   = 2'h3
	} seqState_t;
endpackage

// ### bench/rail_model.sv
// rail comparator model facing the sequencer's channel outputs
// assumes each rail ramps only while its chanOn is high
`timescale 1ns/100ps
module rail_model #(
	parameter int SLOW = 20
) (
	input  wire logic       clock,
	input  wire logic [3:0] chanOn,
	output logic      [3:0] uvAbove
);
	int rampCnt [4] = '{default: 0};
	// odd rails ramp slowly, even rails promptly; a rail that is off reads low
	always @(posedge clock) begin
		for (int i = 0; i < 4; i++) begin
			rampCnt[i] <= chanOn[i] ? rampCnt[i] + 1 : 0;
			uvAbove[i] <= chanOn[i] && (rampCnt[i] >= (i[0] ? SLOW : 2));
		end
	end
endmodule

// ### bench/cascade_power_on_sequencer_tb.sv
// self-checking bench for the cascade power-on sequencer
// assumes rail_model answers uvAbove, registers reached over axi4-lite
`timescale 1ns/100ps
`include "cascade_seq_defs.svh"
module cascade_power_on_sequencer_tb;
	import cascade_seq_pkg::*;
	logic        clock = 0, nrst = 0, clockEn = 1, lockoutClear = 0, powerEnablePin = 0;
	logic [3:0]  uvAbove, chanOn, monitorOn, faultIn = 4'h0, wstrb = 4'hf;
	logic        seqDone, awready, wready, bvalid, arready, rvalid;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, lfsr = 32'hdbe3, cfg;
	logic [1:0]  bresp, rresp;
	logic [33:0] expQ [$];
	logic [1:0]  respQ [$];
	int          miscompares = 0, totalChecks = 0, cycles = 0, onAt [4];

	cascade_power_on_sequencer #(.DLY0_CYC(4), .DLY1_CYC(8), .DLY2_CYC(12), .DLY3_CYC(16)) dut (
		.clock, .nrst, .clockEn, .lockoutClear, .powerEnablePin, .uvAbove, .faultIn,
		.chanOn, .monitorOn, .seqDone, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
		.rdata, .rresp, .rvalid, .rready);
	rail_model rails (.clock, .chanOn, .uvAbove);

	always #4 clock = ~clock;

	function automatic logic [31:0] nextRand(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction

	task automatic testDone();
		$display("checks %0d mismatches %0d", totalChecks, miscompares);
		if (miscompares == 0 && totalChecks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic check(input string what, input logic [33:0] exp, input logic [33:0] got);
		totalChecks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic checkRead(input logic [33:0] exp, input logic [33:0] got);
		totalChecks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD read expected %h seen %h", exp, got);
		end
	endtask

	task automatic checkResp(input logic [1:0] exp, input logic [1:0] got);
		totalChecks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD bresp expected %h seen %h", exp, got);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
		respQ.push_back(resp);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		forever begin
			@(posedge clock);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
			if (bvalid) break;
		end
		bready <= 0;
		tick(1);
	endtask

	task automatic axiRead(input logic [7:0] a, input logic [33:0] exp);
		expQ.push_back(exp);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		forever begin
			@(posedge clock);
			if (arready) arvalid <= 0;
			if (rvalid) break;
		end
		rready <= 0;
		tick(1);
	endtask

	// oldest expected read result or write response against each accepted answer
	always @(posedge clock) begin
		if (rvalid && rready) checkRead(expQ.pop_front(), {rresp, rdata});
		if (bvalid && bready) checkResp(respQ.pop_front(), bresp);
		cycles <= cycles + 1;
		for (int i = 0; i < 4; i++) if (chanOn[i] && onAt[i] < 0) onAt[i] = cycles;
		if (cycles == 20000) begin
			miscompares++;
			testDone();
		end
	end

	task automatic waitDone();
		for (int n = 0; n < 600 && seqDone !== 1'b1; n++) tick(1);
	endtask

	task automatic relock(input logic [31:0] c, input seqMode_t m);
		lockoutClear <= 0;
		tick(8);
		check("off in lockout", 34'h0, {monitorOn, seqDone, chanOn});
		lockoutClear <= 1;
		tick(6);
		cfg = c;
		axiWrite(`ADDR_MODE, {30'h0, m}, `RESP_OKAY);
		axiWrite(`ADDR_CHCFG, c, `RESP_OKAY);
		tick(2); // settling shortened, writes take effect at once
		onAt = '{-1, -1, -1, -1};
	endtask

	initial begin
		tick(12);
		nrst <= 1;
		tick(2);
		axiRead(`ADDR_ENDEF, 34'(`ENDEF_RESET));
		axiRead(8'h40, {`RESP_SLVERR, 32'h0});
		axiWrite(8'h40, 32'h1, `RESP_SLVERR);
		powerEnablePin <= 1;
		tick(20);
		check("pin under lockout", 34'h0, 34'(chanOn));
		powerEnablePin <= 0;
		// normal mode, random positions and delays, pin start
		lfsr = nextRand(nextRand(lfsr));
		relock({8'h0, lfsr[23:16], 8'h0, lfsr[7:0]}, MODE_NORMAL);
		powerEnablePin <= 1;
		waitDone();
		check("normal done", 34'h1ff, {seqDone, monitorOn, chanOn});
		for (int i = 0; i < 4; i++)
			for (int j = 0; j < 4; j++)
				if (cfg[2*i +: 2] < cfg[2*j +: 2])
					check("order", 34'h1, 34'(onAt[i] < onAt[j]));
		powerEnablePin <= 0;
		// with-enable mode, one shared position, command start
		relock(32'h0000e400, MODE_ENABLE);
		axiWrite(`ADDR_ENREG, 32'h0, `RESP_OKAY);
		axiWrite(`ADDR_CTRL, 32'h1, `RESP_OKAY);
		tick(60);
		check("stalled", 34'h0, {seqDone, chanOn});
		axiWrite(`ADDR_ENREG, 32'h5, `RESP_OKAY);
		tick(30);
		check("part enabled", 34'h5, {seqDone, chanOn});
		axiWrite(`ADDR_ENREG, 32'hf, `RESP_OKAY);
		waitDone();
		check("enable done", 34'h1f, {seqDone, chanOn});
		// bypass mode, mixed enable selections
		relock(32'h000064d4, MODE_BYPASS);
		axiRead(`ADDR_ENREG, 34'hf);
		axiWrite(`ADDR_ENREG, 32'h2, `RESP_OKAY);
		axiWrite(`ADDR_CTRL, 32'h1, `RESP_OKAY);
		waitDone();
		check("bypass done", 34'h1a, {seqDone, chanOn});
		axiWrite(`ADDR_ENREG, 32'h6, `RESP_OKAY);
		tick(30);
		check("late enable", 34'h1e, {seqDone, chanOn});
		// manual mode: enables alone, faults ignored, pin as source
		relock(32'h0000e400, MODE_MANUAL);
		axiWrite(`ADDR_ENREG, 32'h0, `RESP_OKAY);
		axiWrite(`ADDR_CTRL, 32'h1, `RESP_OKAY);
		tick(20);
		check("manual idle", 34'h0, 34'(chanOn));
		axiWrite(`ADDR_ENREG, 32'h9, `RESP_OKAY);
		tick(30);
		check("manual on", 34'h9, 34'(chanOn));
		faultIn <= 4'hf;
		tick(20);
		check("manual fault", 34'h9, 34'(chanOn));
		axiWrite(`ADDR_ENDEF, 32'h1f, `RESP_OKAY);
		tick(20);
		check("pin source", 34'h8, 34'(chanOn));
		// auto-start at lockout clear, then a fault on a monitored channel
		faultIn <= 4'h0;
		axiWrite(`ADDR_CTRL, 32'h2, `RESP_OKAY);
		relock(32'h0000e400, MODE_NORMAL);
		waitDone();
		check("auto start", 34'h1ff, {seqDone, monitorOn, chanOn});
		faultIn <= 4'h1;
		tick(10);
		check("fault off", 34'he, 34'(chanOn));
		testDone();
	end
endmodule
